// [verilog/opc_pkg.sv]
// Package for the output protection control block: register map, fields, states.
// Assumes a single 20 MHz core clock and a simple strobe register port.
package opc_pkg;
    // Register offsets (word index on the plain port)
    localparam logic [3:0] OPC_REG_CTRL = 4'h0;
    localparam logic [3:0] OPC_REG_STATUS = 4'h1;
    localparam logic [3:0] OPC_REG_IRQ_STS = 4'h2;
    localparam logic [3:0] OPC_REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] OPC_REG_GPO_SEL = 4'h4;
    // Control fields
    localparam int OPC_CTRL_SPK_ENA = 0;
    localparam int OPC_CTRL_HP_ENA = 2;
    localparam int OPC_CTRL_HP_SC_ENA = 4;
    localparam logic [7:0] OPC_CTRL_RESET = 8'h10;
    // Event bit positions in status, interrupt status and mask
    localparam int OPC_EV_WARN = 0;
    localparam int OPC_EV_HOT = 1;
    localparam int OPC_EV_SPK_DONE = 2;
    localparam int OPC_EV_SPK_SHORT = 3;
    localparam int OPC_EV_HP_SHORT = 4;
    localparam int OPC_EV_W = 5;
    localparam logic [7:0] OPC_MASK_RESET = 8'h00;
    localparam logic [7:0] OPC_GPO_SEL_RESET = 8'h00;
    // Driver shutdown settle time
    localparam int OPC_SHUTDOWN_NS = 1000;
    localparam int OPC_CLK_NS = 50;
    localparam int OPC_SHUTDOWN_CYC = (OPC_SHUTDOWN_NS + OPC_CLK_NS - 1) / OPC_CLK_NS;
    // Per-driver speaker enable states, Gray along the path
    typedef enum logic [2:0] {
        OPC_SPK_OFF = 3'b000,
        OPC_SPK_CHECK = 3'b001,
        OPC_SPK_ON = 3'b011,
        OPC_SPK_STOP = 3'b010,
        OPC_SPK_FAULT = 3'b110,
        OPC_SPK_ARM = 3'b111
    } opc_spk_e;
endpackage

// [verilog/opc_spk_guard.sv]
// Per-speaker-driver enable guard: short check at enable, auto shutdown, recovery.
// Assumes synchronous inputs on core_clk; short sense valid while checked.
`timescale 1ns/100ps
module opc_spk_guard
    import opc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control and sense
    input wire logic enable_req,
    input wire logic short_sense,
    input wire logic overheat,
    // Results
    output logic driver_on,
    output logic short_flag,
    output logic shutdown_done
);
    localparam int CW = $clog2(OPC_SHUTDOWN_CYC + 1);
    opc_spk_e state;
    opc_spk_e next_state;
    logic [CW-1:0] cnt;
    logic en_d;
    wire rise = enable_req && !en_d;
    wire cnt_done = (cnt == CW'(OPC_SHUTDOWN_CYC - 1));

    always_comb begin
        next_state = state;
        case (state)
            OPC_SPK_OFF: if (rise && !overheat) next_state = OPC_SPK_CHECK;
            OPC_SPK_CHECK: begin
                if (!enable_req) next_state = OPC_SPK_OFF;
                // Heat arriving mid-check must not let the driver start
                else if (overheat) next_state = OPC_SPK_STOP;
                else if (short_sense) next_state = OPC_SPK_FAULT;
                else next_state = OPC_SPK_ON;
            end
            OPC_SPK_ON: begin
                if (!enable_req) next_state = OPC_SPK_OFF;
                else if (overheat || short_sense) next_state = OPC_SPK_STOP;
            end
            OPC_SPK_STOP: if (cnt_done) next_state = OPC_SPK_FAULT;
            // Recovery needs disable, enable, disable, enable
            // Level test, so a disable made during the stop still counts
            OPC_SPK_FAULT: if (!enable_req) next_state = OPC_SPK_ARM;
            OPC_SPK_ARM: if (rise) next_state = OPC_SPK_OFF;
            default: next_state = OPC_SPK_OFF;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= OPC_SPK_OFF;
            en_d <= 1'b0;
            cnt <= '0;
            short_flag <= 1'b0;
            shutdown_done <= 1'b0;
            driver_on <= 1'b0;
        end else begin
            state <= next_state;
            en_d <= enable_req;
            cnt <= (state == OPC_SPK_STOP) ? cnt + 1'b1 : '0;
            if (!enable_req) short_flag <= 1'b0;
            else if ((state == OPC_SPK_CHECK || state == OPC_SPK_ON) && short_sense)
                short_flag <= 1'b1;
            shutdown_done <= (state == OPC_SPK_STOP) && cnt_done;
            driver_on <= (next_state == OPC_SPK_ON);
        end
    end
endmodule // opc_spk_guard

// [verilog/opc_hp_guard.sv]
// Per-headphone-channel short detector and current limit control.
// Assumes synchronous positive and negative region short senses.
`timescale 1ns/100ps
module opc_hp_guard (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control and sense
    input wire logic driver_enable,
    input wire logic detect_enable,
    input wire logic short_pos,
    input wire logic short_neg,
    // Results
    output logic short_flag,
    output logic current_limit
);
    // Either region shorted means the channel is shorted
    wire shorted = short_pos || short_neg;
    wire active = driver_enable && detect_enable;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            short_flag <= 1'b0;
            current_limit <= 1'b0;
        end else begin
            short_flag <= active && shorted;
            current_limit <= active && shorted;
        end
    end
endmodule // opc_hp_guard

// [verilog/opc_top.sv]
// Output protection control: thermal events, speaker and headphone short handling.
// Assumes synchronous sensor inputs and a single-cycle strobe register port.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module opc_top
    import opc_pkg::*;
#(
    parameter int N_SPK = 2,
    parameter int N_HP = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Sensors
    input wire logic temp_warning,
    input wire logic temp_overheat,
    input wire logic [N_SPK-1:0] spk_short_sense,
    input wire logic [N_HP-1:0] hp_short_pos,
    input wire logic [N_HP-1:0] hp_short_neg,
    // Driver controls
    output logic [N_SPK-1:0] spk_driver_on,
    output logic [N_HP-1:0] hp_driver_on,
    output logic [N_HP-1:0] hp_current_limit,
    // Indications
    output logic irq,
    output logic gpo
);
    if (N_SPK < 1 || N_SPK > 2 || N_HP < 1 || N_HP > 2) begin : g_bad_count
        $error("opc_top: driver counts must be 1 or 2");
    end

    logic [7:0] ctrl;
    logic [OPC_EV_W-1:0] irq_sts;
    logic [OPC_EV_W-1:0] irq_mask;
    logic [2:0] gpo_sel;
    logic [OPC_EV_W-1:0] ev_prev;

    wire [N_SPK-1:0] spk_on;
    wire [N_SPK-1:0] spk_short;
    wire [N_SPK-1:0] spk_done;
    wire [N_HP-1:0] hp_short;
    wire [N_HP-1:0] hp_limit;

    // Speaker guards; warning is not wired to them so it cannot shut down
    genvar gi;
    generate
        for (gi = 0; gi < N_SPK; gi++) begin : g_spk
            opc_spk_guard u_spk (
                .core_clk(core_clk),
                .reset(reset),
                .enable_req(ctrl[OPC_CTRL_SPK_ENA + gi]),
                .short_sense(spk_short_sense[gi]),
                .overheat(temp_overheat),
                .driver_on(spk_on[gi]),
                .short_flag(spk_short[gi]),
                .shutdown_done(spk_done[gi])
            );
        end
        for (gi = 0; gi < N_HP; gi++) begin : g_hp
            opc_hp_guard u_hp (
                .core_clk(core_clk),
                .reset(reset),
                .driver_enable(ctrl[OPC_CTRL_HP_ENA + gi]),
                .detect_enable(ctrl[OPC_CTRL_HP_SC_ENA]),
                .short_pos(hp_short_pos[gi]),
                .short_neg(hp_short_neg[gi]),
                .short_flag(hp_short[gi]),
                .current_limit(hp_limit[gi])
            );
        end
    endgenerate

    // Live status levels, one per event
    wire [OPC_EV_W-1:0] ev_level;
    assign ev_level[OPC_EV_WARN] = temp_warning;
    assign ev_level[OPC_EV_HOT] = temp_overheat;
    assign ev_level[OPC_EV_SPK_DONE] = |spk_done;
    assign ev_level[OPC_EV_SPK_SHORT] = |spk_short;
    assign ev_level[OPC_EV_HP_SHORT] = |hp_short;
    // Rising edges set the sticky bits, so a held level does not refire
    wire [OPC_EV_W-1:0] ev_rise = ev_level & ~ev_prev;

    // Register decode
    wire wr_ctrl = reg_write && (reg_addr == OPC_REG_CTRL);
    wire wr_clr = reg_write && (reg_addr == OPC_REG_IRQ_STS);
    wire wr_mask = reg_write && (reg_addr == OPC_REG_IRQ_MASK);
    wire wr_gpo = reg_write && (reg_addr == OPC_REG_GPO_SEL);
    wire [OPC_EV_W-1:0] clr_bits = wr_clr ? reg_wdata[OPC_EV_W-1:0] : '0;
    // Set wins over a write-one clear in the same cycle
    wire [OPC_EV_W-1:0] next_irq_sts = (irq_sts & ~clr_bits) | ev_rise;

    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            OPC_REG_CTRL: rd_mux = ctrl;
            OPC_REG_STATUS: rd_mux = 8'(ev_level);
            OPC_REG_IRQ_STS: rd_mux = 8'(irq_sts);
            OPC_REG_IRQ_MASK: rd_mux = 8'(irq_mask);
            OPC_REG_GPO_SEL: rd_mux = 8'(gpo_sel);
            default: rd_mux = 8'h00;
        endcase
    end

    // Unmasked sticky bits drive the level interrupt
    wire next_irq = |(next_irq_sts & ~irq_mask);
    // Selector 0..4 picks one status level, others drive low
    wire next_gpo = (gpo_sel < 3'(OPC_EV_W)) ? ev_level[gpo_sel] : 1'b0;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl <= OPC_CTRL_RESET;
            irq_mask <= OPC_MASK_RESET[OPC_EV_W-1:0];
            gpo_sel <= OPC_GPO_SEL_RESET[2:0];
            irq_sts <= '0;
            ev_prev <= '0;
            reg_rdata <= 8'h00;
            irq <= 1'b0;
            gpo <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl <= reg_wdata;
            if (wr_mask) irq_mask <= reg_wdata[OPC_EV_W-1:0];
            if (wr_gpo) gpo_sel <= reg_wdata[2:0];
            irq_sts <= next_irq_sts;
            ev_prev <= ev_level;
            reg_rdata <= reg_read ? rd_mux : 8'h00;
            irq <= next_irq;
            gpo <= next_gpo;
        end
    end

    // Driver outputs straight from flops
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            spk_driver_on <= '0;
            hp_driver_on <= '0;
            hp_current_limit <= '0;
        end else begin
            spk_driver_on <= spk_on;
            hp_driver_on <= ctrl[OPC_CTRL_HP_ENA +: N_HP];
            hp_current_limit <= hp_limit;
        end
    end
endmodule // opc_top

// [sim/opc_top_sva.sv]
// Port checker for opc_top: register port, speaker guard, headphone limit.
// Assumes it is bound onto opc_top with the same parameters.
`timescale 1ns/100ps
module opc_top_sva
    import opc_pkg::*;
#(
    parameter int N_SPK = 2,
    parameter int N_HP = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Sensors
    input wire logic temp_warning,
    input wire logic temp_overheat,
    input wire logic [N_SPK-1:0] spk_short_sense,
    input wire logic [N_HP-1:0] hp_short_pos,
    input wire logic [N_HP-1:0] hp_short_neg,
    // Driver controls
    input wire logic [N_SPK-1:0] spk_driver_on,
    input wire logic [N_HP-1:0] hp_driver_on,
    input wire logic [N_HP-1:0] hp_current_limit
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    a_sel_readback: assert property (reg_write && reg_addr == OPC_REG_GPO_SEL ##1 reg_read && reg_addr == OPC_REG_GPO_SEL |=> reg_rdata == ($past(reg_wdata, 2) & 8'h07))
        else $error("output select readback wrong");
    a_spk_on_cause: assert property ($rose(spk_driver_on[0]) |-> $past(reg_write, 4))
        else $error("speaker on without enable write");
    a_short_off: assert property (spk_short_sense[1] [*4] |-> !spk_driver_on[1])
        else $error("shorted speaker still driven");
    a_heat_off: assert property (temp_overheat [*4] |-> spk_driver_on == '0)
        else $error("speaker driven while overheated");
    a_warn_only: assert property ((temp_warning && !temp_overheat && spk_short_sense == '0 && !reg_write) [*5] |-> $stable(spk_driver_on))
        else $error("warning changed speaker drivers");
    a_hp_kept: assert property (!$past(reg_write, 2) |-> $stable(hp_driver_on))
        else $error("headphone driver changed without write");
    a_limit_cause: assert property ((hp_current_limit & ~($past(hp_short_pos | hp_short_neg, 1) | $past(hp_short_pos | hp_short_neg, 2))) == '0)
        else $error("current limit without short");
endmodule // opc_top_sva

// [sim/tb_output_protection_control.sv]
// Testbench for opc_top: speaker guard, thermal events, headphone limit, irq.
// Assumes opc_pkg, the design and opc_top_sva are compiled first.
`timescale 1ns/100ps
module tb_output_protection_control;
    import opc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic temp_warning = 1'b0;
    logic temp_overheat = 1'b0;
    logic [1:0] spk_short_sense = 2'b00;
    logic [1:0] hp_short_pos = 2'b00;
    logic [1:0] hp_short_neg = 2'b00;
    logic [7:0] reg_rdata;
    logic [1:0] spk_driver_on, hp_driver_on, hp_current_limit, p, n;
    logic irq, gpo;
    logic pend = 1'b0;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int checked = 0;
    int seed;
    opc_top dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .temp_warning(temp_warning), .temp_overheat(temp_overheat),
        .spk_short_sense(spk_short_sense), .hp_short_pos(hp_short_pos),
        .hp_short_neg(hp_short_neg), .spk_driver_on(spk_driver_on),
        .hp_driver_on(hp_driver_on), .hp_current_limit(hp_current_limit), .irq(irq), .gpo(gpo));
    always #25 core_clk = ~core_clk;
    task automatic wrap_up;
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    // Expected read data queued here, compared by the watcher
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        reg_addr <= a;
        exp_q.push_back(e);
    endtask
    task automatic idle(input int k);
        repeat (k) begin
            @(posedge core_clk);
            reg_write <= 1'b0;
            reg_read <= 1'b0;
        end
        @(negedge core_clk);
    endtask
    // Fault recovery needs this disable then enable run twice
    task automatic cycle_spk;
        wr(OPC_REG_CTRL, 8'h10);
        idle(2);
        wr(OPC_REG_CTRL, 8'h13);
        idle(5);
    endtask
    always @(posedge core_clk) pend <= reg_read;
    always @(negedge core_clk) begin
        if (pend && exp_q.size() > 0)
            check(reg_rdata, exp_q.pop_front());
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        seed = $urandom(32'h6339);
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(OPC_REG_CTRL, OPC_CTRL_RESET);
        rd(OPC_REG_IRQ_MASK, OPC_MASK_RESET);
        rd(4'hf, 8'h00);
        wr(OPC_REG_CTRL, 8'h13);
        spk_short_sense <= 2'b10;
        idle(5);
        check({6'h00, spk_driver_on}, 8'h01);
        rd(OPC_REG_STATUS, 8'h08);
        rd(OPC_REG_IRQ_STS, 8'h08);
        idle(1);
        check({7'h00, irq}, 8'h01);
        wr(OPC_REG_CTRL, 8'h10);
        wr(OPC_REG_IRQ_STS, 8'h1f);
        idle(2);
        check({7'h00, irq}, 8'h00);
        rd(OPC_REG_STATUS, 8'h00);
        wr(OPC_REG_CTRL, 8'h13);
        spk_short_sense <= 2'b00;
        idle(5);
        check({6'h00, spk_driver_on}, 8'h01);
        cycle_spk();
        check({6'h00, spk_driver_on}, 8'h03);
        @(posedge core_clk);
        temp_overheat <= 1'b1;
        idle(4);
        check({6'h00, spk_driver_on}, 8'h00);
        idle(OPC_SHUTDOWN_CYC + 4);
        rd(OPC_REG_IRQ_STS, 8'h06);
        idle(1);
        check({7'h00, irq}, 8'h01);
        wr(OPC_REG_IRQ_MASK, 8'h1f);
        idle(2);
        check({7'h00, irq}, 8'h00);
        wr(OPC_REG_IRQ_STS, 8'h1f);
        wr(OPC_REG_IRQ_MASK, 8'h00);
        temp_overheat <= 1'b0;
        idle(2);
        check({7'h00, irq}, 8'h00);
        cycle_spk();
        cycle_spk();
        @(posedge core_clk);
        temp_warning <= 1'b1;
        idle(6);
        check({6'h00, spk_driver_on}, 8'h03);
        rd(OPC_REG_IRQ_STS, 8'h01);
        wr(OPC_REG_IRQ_STS, 8'h1f);
        temp_warning <= 1'b0;
        wr(OPC_REG_GPO_SEL, 8'h04);
        rd(OPC_REG_GPO_SEL, 8'h04);
        wr(OPC_REG_CTRL, 8'h1f);
        idle(2);
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            p = 2'($urandom);
            n = 2'($urandom);
            hp_short_pos <= p;
            hp_short_neg <= n;
            idle(4);
            check({6'h00, hp_current_limit}, {6'h00, p | n});
            check({6'h00, hp_driver_on}, 8'h03);
            check({7'h00, gpo}, {7'h00, |(p | n)});
        end
        @(posedge core_clk);
        hp_short_pos <= 2'b11;
        rd(OPC_REG_CTRL, 8'h1f);
        wr(OPC_REG_CTRL, 8'h0f);
        idle(4);
        check({6'h00, hp_current_limit}, 8'h00);
        rd(OPC_REG_STATUS, 8'h00);
        wr(OPC_REG_CTRL, 8'h13);
        idle(4);
        check({6'h00, hp_current_limit}, 8'h00);
        // Short while running: driver drops on its own
        @(posedge core_clk);
        spk_short_sense <= 2'b01;
        idle(4);
        check({6'h00, spk_driver_on}, 8'h02);
        rd(OPC_REG_STATUS, 8'h08);
        idle(2);
        wrap_up();
    end
endmodule // tb_output_protection_control
bind opc_top opc_top_sva #(.N_SPK(N_SPK), .N_HP(N_HP)) u_sva (.core_clk(core_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .temp_warning(temp_warning),
    .temp_overheat(temp_overheat), .spk_short_sense(spk_short_sense),
    .hp_short_pos(hp_short_pos), .hp_short_neg(hp_short_neg), .spk_driver_on(spk_driver_on),
    .hp_driver_on(hp_driver_on), .hp_current_limit(hp_current_limit));
